// *** include/mac_port_pkg.sv ***
// Contract
// (RQ1) mii nibbles follow tx clock, lsb first
// (RQ2) mii tx clock 2.5 or 25 mhz
// (RQ3) mii tx enable rises with first preamble
// (RQ4) dte takes phy clock, dce makes it
// (RQ5) phy carrier covers tx and rx activity
// (RQ6) collision replaces frame with 55555555h jam
// (RQ7) random wait then retry, 16 tries max
// (RQ8) sync col and crs, half duplex only
// (RQ9) phy rx nibbles follow 2.5/25 mhz clock
// (RQ10) rx valid from preamble or delimiter
// (RQ11) accept only when valid, no error
// (RQ12) dce holds rx error input low
// (RQ13) rmii tx enable with first preamble bit
// (RQ14) rmii dibits follow 50 mhz reference
// (RQ15) rmii 10m dibit held ten clocks
// (RQ16) rmii rx dibits sampled on rising edge
// (RQ17) rmii dibits valid only with carrier valid
// (RQ18) carrier valid synchronised before use
// (RQ19) backoff is truncated binary exponential slots
// (RQ20) frame dropped after last failed attempt
`default_nettype none
package mac_port_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXLEN = 8'h08;
  localparam logic [7:0] OFS_TXBUF = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam int CTRL_RMII = 0;
  localparam int CTRL_SPEED100 = 1;
  localparam int CTRL_HALF = 2;
  localparam int CTRL_DCE = 3;
  localparam int CTRL_GO = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int ST_BUSY = 0;
  localparam int ST_ATTEMPT_LSB = 4;
  localparam int ST_DROP = 12;
  localparam int ST_RXVALID = 13;
  localparam int ST_RXOVR = 14;
  localparam int RX_VALID_BIT = 8;
  // ==========================================================
  // frame buffer
  localparam int BUF_DEPTH = 64;
  localparam int BUF_AW = 6;
  localparam int LEN_W = 7;
  // ==========================================================
  // frame format and half duplex
  localparam logic [6:0] PRE_BYTES = 7'd7;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [31:0] JAM_PAT = 32'h55555555;
  localparam logic [3:0] JAM_SYM_MII = 4'd8;
  localparam logic [4:0] JAM_SYM_RMII = 5'd16;
  localparam logic [4:0] MAX_ATTEMPTS = 5'd16;
  localparam logic [4:0] BACKOFF_LIMIT = 5'd10;
  localparam int SLOT_SHIFT_MII = 7;
  localparam int SLOT_SHIFT_RMII = 8;
  // ==========================================================
  // clocking
  localparam int CLK_HZ = 50_000_000;
  localparam int MII_FAST_HZ = 25_000_000;
  localparam int MII_SLOW_HZ = 2_500_000;
  localparam logic [3:0] HALF_FAST = 4'(CLK_HZ / (2 * MII_FAST_HZ));
  localparam logic [3:0] HALF_SLOW = 4'(CLK_HZ / (2 * MII_SLOW_HZ));
  localparam logic [3:0] RMII_SLOW_DIV = 4'd10;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [2:0] {TX_IDLE, TX_DEFER, TX_SEND, TX_TAIL, TX_JAM, TX_BACKOFF} tx_state_t;
endpackage : mac_port_pkg
`default_nettype wire

// *** logic/mii_rmii_mac_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module mii_rmii_mac_port (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_tx_clk,
  output logic o_tx_clk,
  output logic o_tx_clk_oe,
  output logic [3:0] o_txd,
  output logic o_tx_en,
  input wire logic i_col,
  input wire logic i_crs,
  input wire logic i_rx_clk,
  input wire logic [3:0] i_rxd,
  input wire logic i_rx_dv,
  input wire logic i_rx_er
);
  import mac_port_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [9:0] pins_s;
  logic txclk_s, col_s, crs_s, rxclk_s, dv_s, er_s;
  logic [3:0] rxd_s;

  pin_sync #(.W(10)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_d({i_tx_clk, i_col, i_crs, i_rx_clk, i_rx_dv, i_rx_er, i_rxd}),
    .o_q(pins_s)
  );
  assign {txclk_s, col_s, crs_s, rxclk_s, dv_s, er_s, rxd_s} = pins_s; // RQ8 RQ18

  // ==========================================================
  // edges and clock generation
  logic [3:0] ctrl_r;
  logic rmii, spd100, half, dce;
  assign rmii = ctrl_r[CTRL_RMII];
  assign spd100 = ctrl_r[CTRL_SPEED100];
  assign half = ctrl_r[CTRL_HALF];
  assign dce = ctrl_r[CTRL_DCE];

  logic txclk_d_r, txclk_d_nxt, rxclk_d_r, rxclk_d_nxt;
  logic [5:0] rxq_r, rxq_nxt;
  logic [3:0] div_r, div_nxt, rdiv_r, rdiv_nxt;
  logic gclk_r, gclk_nxt;
  logic [3:0] half_cnt;
  logic gen_fall, rmii_tick, tx_tick, rx_tick;

  always_comb begin
    half_cnt = spd100 ? HALF_FAST : HALF_SLOW; // RQ2
    txclk_d_nxt = txclk_s;
    rxclk_d_nxt = rxclk_s;
    rxq_nxt = {dv_s, er_s, rxd_s};
    div_nxt = div_r + 4'd1;
    gclk_nxt = gclk_r;
    gen_fall = 1'b0;
    if (div_r == half_cnt - 4'd1) begin
      div_nxt = 4'd0;
      gclk_nxt = ~gclk_r; // RQ4
      gen_fall = gclk_r;
    end
    rdiv_nxt = (rdiv_r == RMII_SLOW_DIV - 4'd1) ? 4'd0 : rdiv_r + 4'd1;
    rmii_tick = spd100 || (rdiv_r == RMII_SLOW_DIV - 4'd1); // RQ15
    // in dce mii data moves on the falling edge of our own clock for clean phy setup; dte mii uses the phy clock rise, rmii the tick
    tx_tick = rmii ? rmii_tick : (dce ? gen_fall : (txclk_s & ~txclk_d_r)); // RQ1 RQ4 RQ14
    rx_tick = rmii ? rmii_tick : (rxclk_s & ~rxclk_d_r); // RQ16
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      txclk_d_r <= 1'b0;
      rxclk_d_r <= 1'b0;
      rxq_r <= 6'h00;
      div_r <= 4'd0;
      rdiv_r <= 4'd0;
      gclk_r <= 1'b0;
    end else if (i_ce) begin
      txclk_d_r <= txclk_d_nxt;
      rxclk_d_r <= rxclk_d_nxt;
      rxq_r <= rxq_nxt;
      div_r <= div_nxt;
      rdiv_r <= rdiv_nxt;
      gclk_r <= gclk_nxt;
    end
  end

  assign o_tx_clk = gclk_r;
  assign o_tx_clk_oe = dce & ~rmii; // RQ4

  // ==========================================================
  // transmit engine
  tx_state_t st_r, st_nxt;
  logic [6:0] bidx_r, bidx_nxt;
  logic [1:0] sub_r, sub_nxt;
  logic [3:0] txd_r, txd_nxt;
  logic txen_r, txen_nxt;
  logic [4:0] att_r, att_nxt, jam_r, jam_nxt;
  logic [17:0] bo_r, bo_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [LEN_W-1:0] txlen_r;
  logic [7:0] buf_r [BUF_DEPTH];
  logic go, tx_done, tx_drop;
  logic [7:0] cur_byte, sh;
  logic [31:0] jsh;
  logic [3:0] sym, jsym;
  logic last_sym, jam_end;
  logic [4:0] k;
  logic [9:0] rnd;
  logic [6:0] dpos;

  always_comb begin
    st_nxt = st_r;
    bidx_nxt = bidx_r;
    sub_nxt = sub_r;
    txd_nxt = txd_r;
    txen_nxt = txen_r;
    att_nxt = att_r;
    jam_nxt = jam_r;
    bo_nxt = bo_r;
    lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    tx_done = 1'b0;
    tx_drop = 1'b0;
    dpos = bidx_r - PRE_BYTES - 7'd1;
    if (bidx_r < PRE_BYTES) begin
      cur_byte = PRE_BYTE;
    end else if (bidx_r == PRE_BYTES) begin
      cur_byte = SFD_BYTE;
    end else begin
      cur_byte = buf_r[dpos[BUF_AW-1:0]];
    end
    sh = cur_byte >> (rmii ? {sub_r, 1'b0} : {sub_r[0], 2'b00}); // RQ1
    sym = rmii ? {2'b00, sh[1:0]} : sh[3:0];
    jsh = JAM_PAT >> (rmii ? {jam_r[3:0], 1'b0} : {jam_r[2:0], 2'b00});
    jsym = rmii ? {2'b00, jsh[1:0]} : jsh[3:0]; // RQ6
    last_sym = (sub_r == (rmii ? 2'd3 : 2'd1)) && (bidx_r == PRE_BYTES + 7'(txlen_r));
    jam_end = rmii ? (jam_r == JAM_SYM_RMII) : (jam_r == {1'b0, JAM_SYM_MII});
    k = (att_r + 5'd1 > BACKOFF_LIMIT) ? BACKOFF_LIMIT : att_r + 5'd1;
    rnd = lfsr_r[9:0] & 10'((11'd1 << k) - 11'd1); // RQ19
    unique case (st_r)
      TX_IDLE: begin
        if (go && txlen_r != '0) begin
          att_nxt = 5'd0;
          st_nxt = TX_DEFER;
        end
      end
      TX_DEFER: begin
        // carrier only gates start in half duplex
        if (!(half && crs_s)) begin // RQ8 RQ5
          bidx_nxt = 7'd0;
          sub_nxt = 2'd0;
          st_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_tick) begin
          txen_nxt = 1'b1; // RQ3 RQ13
          if (half && col_s) begin // RQ6 RQ8
            txd_nxt = jsym;
            jam_nxt = 5'd1;
            st_nxt = TX_JAM;
          end else begin
            txd_nxt = sym; // RQ1 RQ14
            sub_nxt = sub_r + 2'd1;
            if (sub_r == (rmii ? 2'd3 : 2'd1)) begin
              sub_nxt = 2'd0;
              bidx_nxt = bidx_r + 7'd1;
            end
            if (last_sym) begin
              st_nxt = TX_TAIL;
            end
          end
        end
      end
      TX_TAIL: begin
        if (tx_tick) begin
          txen_nxt = 1'b0;
          txd_nxt = 4'h0;
          tx_done = 1'b1;
          st_nxt = TX_IDLE;
        end
      end
      TX_JAM: begin
        if (tx_tick) begin
          if (jam_end) begin
            txen_nxt = 1'b0;
            txd_nxt = 4'h0;
            att_nxt = att_r + 5'd1;
            if (att_r + 5'd1 == MAX_ATTEMPTS) begin // RQ7
              tx_drop = 1'b1; // RQ20
              tx_done = 1'b1;
              st_nxt = TX_IDLE;
            end else begin
              bo_nxt = rmii ? {rnd, 8'h00} : {1'b0, rnd, 7'h00}; // RQ19
              st_nxt = TX_BACKOFF;
            end
          end else begin
            txd_nxt = jsym;
            jam_nxt = jam_r + 5'd1;
          end
        end
      end
      TX_BACKOFF: begin
        if (bo_r == 18'd0) begin
          st_nxt = TX_DEFER; // RQ7
        end else if (tx_tick) begin
          bo_nxt = bo_r - 18'd1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= TX_IDLE;
      bidx_r <= 7'd0;
      sub_r <= 2'd0;
      txd_r <= 4'h0;
      txen_r <= 1'b0;
      att_r <= 5'd0;
      jam_r <= 5'd0;
      bo_r <= 18'd0;
      lfsr_r <= LFSR_SEED;
    end else if (i_ce) begin
      st_r <= st_nxt;
      bidx_r <= bidx_nxt;
      sub_r <= sub_nxt;
      txd_r <= txd_nxt;
      txen_r <= txen_nxt;
      att_r <= att_nxt;
      jam_r <= jam_nxt;
      bo_r <= bo_nxt;
      lfsr_r <= lfsr_nxt;
    end
  end

  assign o_txd = txd_r;
  assign o_tx_en = txen_r;

  // ==========================================================
  // receive engine
  logic [7:0] acc_r, acc_nxt;
  logic [1:0] rcnt_r, rcnt_nxt;
  logic rx_ok, byte_done;

  always_comb begin
    acc_nxt = acc_r;
    rcnt_nxt = rcnt_r;
    byte_done = 1'b0;
    rx_ok = rmii ? rxq_r[5] : (rxq_r[5] && !(rxq_r[4] && !dce)); // RQ11 RQ17 RQ12
    if (rx_tick) begin
      if (rx_ok) begin
        acc_nxt = rmii ? {rxq_r[1:0], acc_r[7:2]} : {rxq_r[3:0], acc_r[7:4]};
        rcnt_nxt = rcnt_r + 2'd1;
        if (rcnt_r == (rmii ? 2'd3 : 2'd1)) begin
          rcnt_nxt = 2'd0;
          byte_done = 1'b1;
        end
      end else begin
        // dropped carrier restarts byte alignment
        rcnt_nxt = 2'd0; // RQ18
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_r <= 8'h00;
      rcnt_r <= 2'd0;
    end else if (i_ce) begin
      acc_r <= acc_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end

  // ==========================================================
  // apb register slave
  logic [3:0] ctrl_nxt;
  logic [LEN_W-1:0] txlen_nxt;
  logic [7:0] buf_nxt [BUF_DEPTH];
  logic drop_r, drop_nxt, rxv_r, rxv_nxt, ovr_r, ovr_nxt;
  logic [7:0] rxb_r, rxb_nxt;
  logic [31:0] prdata_nxt;
  logic wr, rd, setup, mapped, busy;

  always_comb begin
    setup = i_psel && !i_penable;
    wr = i_psel && i_penable && i_pwrite;
    rd = i_psel && i_penable && !i_pwrite;
    mapped = (i_paddr == OFS_CTRL) || (i_paddr == OFS_STATUS) || (i_paddr == OFS_TXLEN)
      || (i_paddr == OFS_TXBUF) || (i_paddr == OFS_RXDATA);
    busy = (st_r != TX_IDLE);
    ctrl_nxt = ctrl_r;
    txlen_nxt = txlen_r;
    buf_nxt = buf_r;
    drop_nxt = drop_r;
    rxv_nxt = rxv_r;
    ovr_nxt = ovr_r;
    rxb_nxt = rxb_r;
    go = 1'b0;
    prdata_nxt = o_prdata;
    if (wr && i_paddr == OFS_CTRL) begin
      // mode changes only while the transmitter is idle so a sent frame never switches format midway
      if (!busy) begin
        ctrl_nxt = i_pwdata[3:0];
      end
      go = i_pwdata[CTRL_GO];
    end
    if (wr && i_paddr == OFS_TXBUF && !busy && txlen_r != LEN_W'(BUF_DEPTH)) begin
      buf_nxt[txlen_r[BUF_AW-1:0]] = i_pwdata[7:0];
      txlen_nxt = txlen_r + 7'd1;
    end
    if (wr && i_paddr == OFS_TXLEN && !busy) begin
      txlen_nxt = 7'd0;
    end
    if (tx_done) begin
      txlen_nxt = 7'd0; // RQ20
    end
    if (wr && i_paddr == OFS_STATUS) begin
      drop_nxt = drop_r & ~i_pwdata[ST_DROP];
      ovr_nxt = ovr_r & ~i_pwdata[ST_RXOVR];
    end
    if (rd && i_paddr == OFS_RXDATA) begin
      rxv_nxt = 1'b0;
    end
    // hardware set beats software clear
    if (tx_drop) begin
      drop_nxt = 1'b1;
    end
    if (byte_done) begin
      if (rxv_r && !(rd && i_paddr == OFS_RXDATA)) begin
        ovr_nxt = 1'b1;
      end
      rxv_nxt = 1'b1;
      rxb_nxt = acc_nxt;
    end
    if (setup) begin
      prdata_nxt = 32'h0;
      if (i_paddr == OFS_CTRL) begin
        prdata_nxt[3:0] = ctrl_r;
      end else if (i_paddr == OFS_STATUS) begin
        prdata_nxt[ST_BUSY] = busy;
        prdata_nxt[ST_ATTEMPT_LSB +: 5] = att_r;
        prdata_nxt[ST_DROP] = drop_r;
        prdata_nxt[ST_RXVALID] = rxv_r;
        prdata_nxt[ST_RXOVR] = ovr_r;
      end else if (i_paddr == OFS_TXLEN) begin
        prdata_nxt[LEN_W-1:0] = txlen_r;
      end else if (i_paddr == OFS_RXDATA) begin
        prdata_nxt[7:0] = rxb_r;
        prdata_nxt[RX_VALID_BIT] = rxv_r;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_r <= CTRL_RST;
      txlen_r <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_r[i] <= 8'h00;
      end
      drop_r <= 1'b0;
      rxv_r <= 1'b0;
      ovr_r <= 1'b0;
      rxb_r <= 8'h00;
      o_prdata <= 32'h0;
    end else if (i_ce) begin
      ctrl_r <= ctrl_nxt;
      txlen_r <= txlen_nxt;
      buf_r <= buf_nxt;
      drop_r <= drop_nxt;
      rxv_r <= rxv_nxt;
      ovr_r <= ovr_nxt;
      rxb_r <= rxb_nxt;
      o_prdata <= prdata_nxt;
    end
  end

  // a frozen block holds the bus; writes are kept but a read set up while frozen returns the old o_prdata
  assign o_pready = i_ce;
  assign o_pslverr = i_psel && i_penable && !mapped;
endmodule : mii_rmii_mac_port
`default_nettype wire

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // first stage feeds only the second one
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = i_ce ? i_d : meta_r;
    q_nxt = i_ce ? meta_r : o_q;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= meta_nxt;
      o_q <= q_nxt;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** test/mac_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_port_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_tx_clk,
  input wire logic o_tx_clk_oe,
  input wire logic [3:0] o_txd,
  input wire logic o_tx_en
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire logic acc = i_psel && i_penable;
  wire logic aligned = i_paddr <= 8'h10 && i_paddr[1:0] == 2'h0;
  // ==========================================================
  // bus
  ready_ce_a: assert property (o_pready == i_ce) else $error("pready differs from clock enable");
  err_phase_a: assert property (o_pslverr |-> acc) else $error("slave error outside access phase");
  err_unmapped_a: assert property (acc && i_paddr > 8'h10 |-> o_pslverr) else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && aligned |-> !o_pslverr) else $error("mapped access refused");
  // ==========================================================
  // link
  sequence pre_sym_s;
    o_tx_en && o_txd[1:0] == 2'h1;
  endsequence
  tx_start_a: assert property ($rose(o_tx_en) |-> pre_sym_s [*8]) else $error("frame not opened by preamble");
  idle_zero_a: assert property (!o_tx_en |-> o_txd == 4'h0) else $error("data lines busy while idle");
  clk_half_a: assert property (o_tx_clk_oe && $rose(o_tx_clk) |-> ##[1:11] (!o_tx_clk || !o_tx_clk_oe))
    else $error("generated clock high too long");
  rst_quiet_a: assert property ($fell(i_sys_rst) |-> !o_tx_en && o_txd == 4'h0 && !o_tx_clk)
    else $error("link not quiet after reset");
endmodule : mac_port_sva
`default_nettype wire

// *** test/phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  input wire logic i_clk,
  input wire logic i_rmii,
  input wire logic i_tx_clk,
  input wire logic [3:0] i_txd,
  input wire logic i_tx_en,
  output logic [3:0] o_rxd,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic o_crs,
  output logic o_clk
);
  logic [3:0] cap[$];
  // link clock parked low outside received mii frames
  initial begin
    o_rxd = 4'h0;
    o_rx_dv = 1'b0;
    o_rx_er = 1'b0;
    o_crs = 1'b0;
    o_clk = 1'b0;
  end
  always @(posedge i_clk) begin
    o_crs <= i_tx_en || o_rx_dv;
    if (i_rmii && i_tx_en) begin
      cap.push_back(i_txd);
    end
  end
  always @(posedge i_tx_clk) begin
    if (!i_rmii && i_tx_en) begin
      cap.push_back(i_txd);
    end
  end
  task automatic rx_byte(input logic [7:0] b);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      o_rxd <= {2'b00, b[2*i+:2]};
      o_rx_dv <= 1'b1;
    end
    @(posedge i_clk);
    o_rx_dv <= 1'b0;
    // released line must not look like a held dibit
    o_rxd <= ~o_rxd;
  endtask : rx_byte
  // 2.5 mhz nibble clock; the opening nibble is flagged bad and must be skipped
  task automatic rx_mii(input logic [7:0] b);
    for (int i = 0; i < 3; i++) begin
      repeat (10) @(posedge i_clk);
      o_clk <= 1'b0;
      o_rxd <= (i == 2) ? b[7:4] : b[3:0] ^ {4{i == 0}};
      o_rx_dv <= 1'b1;
      o_rx_er <= (i == 0);
      repeat (10) @(posedge i_clk);
      o_clk <= 1'b1;
    end
    repeat (10) @(posedge i_clk);
    o_clk <= 1'b0;
    o_rx_dv <= 1'b0;
    o_rx_er <= 1'b0;
    o_rxd <= ~o_rxd;
  endtask : rx_mii
endmodule : phy_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mac_port_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic col = 1'b0;
  logic rmii = 1'b1;
  logic ce = 1'b1;
  logic err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, tx_clk, tx_clk_oe, tx_en, rx_dv, rx_er, crs, phy_clk;
  logic [3:0] txd, rxd;
  logic [7:0] frame[$];
  int n_errors = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  mii_rmii_mac_port u_dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_tx_clk(phy_clk), .o_tx_clk(tx_clk), .o_tx_clk_oe(tx_clk_oe), .o_txd(txd),
    .o_tx_en(tx_en), .i_col(col), .i_crs(crs), .i_rx_clk(phy_clk), .i_rxd(rxd), .i_rx_dv(rx_dv),
    .i_rx_er(rx_er));
  phy_model u_phy (.i_clk(clk), .i_rmii(rmii), .i_tx_clk(tx_clk), .i_txd(txd), .i_tx_en(tx_en),
    .o_rxd(rxd), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs), .o_clk(phy_clk));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // bus master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so a following call never redrives psel in this step
    @(posedge clk);
  endtask : apb
  task automatic wait_idle();
    int t;
    t = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      t++;
    end while (rd[ST_BUSY] !== 1'b0 && t < 4000);
    if (rd[ST_BUSY] !== 1'b0) begin
      n_errors++;
      $display("Error at %0t: transmitter stuck busy", $time);
    end
  endtask : wait_idle
  // ==========================================================
  // one frame; every held sample is compared, so hold length counts
  task automatic send(input logic [7:0] ctrl, input int stride, input int sym);
    logic [7:0] b[$];
    int n;
    n = 8 / sym;
    for (int i = 0; i < 7; i++) b.push_back(PRE_BYTE);
    b.push_back(SFD_BYTE);
    foreach (frame[i]) b.push_back(frame[i]);
    apb(1'b1, OFS_TXLEN, 32'h0);
    foreach (frame[i]) apb(1'b1, OFS_TXBUF, {24'h0, frame[i]});
    u_phy.cap.delete();
    apb(1'b1, OFS_CTRL, {24'h0, ctrl});
    wait_idle();
    check(32'(u_phy.cap.size()), 32'(b.size() * n * stride));
    foreach (u_phy.cap[i]) check(32'(u_phy.cap[i]), 32'((b[i / stride / n] >> (i / stride % n * sym)) & (sym == 2 ? 8'h3 : 8'hf)));
  endtask : send
  task automatic jam();
    logic [3:0] s[$];
    @(posedge tx_en);
    repeat (36) @(posedge clk);
    col <= 1'b1;
    repeat (3) @(posedge clk);
    col <= 1'b0;
    @(negedge tx_en);
    s = u_phy.cap;
    u_phy.cap.delete();
    for (int i = 1; i <= 16; i++) check(32'(s[s.size() - i]), 32'(JAM_PAT[1:0]));
  endtask : jam
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, {28'h0, CTRL_RST});
    fork
      apb(1'b1, OFS_CTRL, 32'(1 << CTRL_HALF));
      begin
        ce <= 1'b0;
        repeat (6) @(posedge clk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'(1 << CTRL_HALF));
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test registers done");
    frame = '{8'ha3, 8'h3c, 8'h0f, 8'hf0};
    col <= 1'b1;
    send(8'h13, 1, 2);
    col <= 1'b0;
    send(8'h11, 10, 2);
    $display("test rmii transmit done");
    rmii <= 1'b0;
    send(8'h1a, 1, 4);
    check({31'h0, tx_clk_oe}, 32'h1);
    $display("test mii transmit done");
    apb(1'b1, OFS_CTRL, 32'h0);
    check({31'h0, tx_clk_oe}, 32'h0);
    u_phy.rx_mii(SFD_BYTE);
    apb(1'b0, OFS_RXDATA, 32'h0);
    check(rd, {23'h0, 1'b1, SFD_BYTE});
    $display("test mii receive done");
    rmii <= 1'b1;
    fork
      send(8'h17, 1, 2);
      jam();
    join
    apb(1'b0, OFS_STATUS, 32'h0);
    check(32'(rd[ST_ATTEMPT_LSB +: 5]), 32'h1);
    check(32'(rd[ST_DROP]), 32'h0);
    $display("test collision done");
    u_phy.rx_byte(8'hb4);
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_RXDATA, 32'h0);
    check(rd, 32'h1b4);
    apb(1'b0, OFS_RXDATA, 32'h0);
    check(rd & 32'h100, 32'h0);
    $display("test rmii receive done");
    end_sim();
  end
  initial begin
    #1_000_000;
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    end_sim();
  end
endmodule : testbench
bind mii_rmii_mac_port mac_port_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_tx_clk(o_tx_clk),
  .o_tx_clk_oe(o_tx_clk_oe), .o_txd(o_txd), .o_tx_en(o_tx_en));
`default_nettype wire
